//--- logic/sysctl_pkg.sv
// Shared constants and types for the peripheral bus bridge and system block
package sysctl_pkg;
	// Register addresses, word aligned; address bit 0 is never decoded
	localparam logic [15:0] CTRL_ADDR     = 16'h7018;
	localparam logic [15:0] STAT_ADDR     = 16'h701A;
	localparam logic [15:0] VEC_ADDR      = 16'h701E;
	localparam logic [15:0] SYS_BASE      = 16'h7010;
	localparam logic [15:0] SYS_MASK      = 16'hFFF0;
	localparam logic [15:0] PER_BASE      = 16'h7000;
	localparam logic [15:0] PER_MASK      = 16'hF000;
	localparam logic [15:0] EV_BASE       = 16'h7400;
	localparam logic [15:0] EV_MASK       = 16'hFFC0;
	// Control register fields
	localparam int          SRST_HI_BIT   = 15;
	localparam int          SRST_LO_BIT   = 14;
	localparam int          CKSEL_HI_BIT  = 7;
	localparam int          CKSEL_LO_BIT  = 6;
	localparam logic [1:0]  SRST_RESET    = 2'h1;
	localparam logic [1:0]  SRST_NOP      = 2'h1;
	localparam logic [1:0]  CKSEL_POR     = 2'h3;
	// Status register fields
	localparam int          ST_POR_BIT    = 15;
	localparam int          ST_BAD_BIT    = 12;
	localparam int          ST_SW_BIT     = 10;
	localparam int          ST_WD_BIT     = 9;
	localparam int          ST_HPO_BIT    = 5;
	localparam int          ST_AF_BIT     = 3;
	localparam int          ST_VEC_BIT    = 0;
	// Clock output sources
	localparam logic [1:0]  CKO_GPIO      = 2'h0;
	localparam logic [1:0]  CKO_WDOG      = 2'h1;
	localparam logic [1:0]  CKO_PER       = 2'h2;
	localparam logic [1:0]  CKO_CORE      = 2'h3;
	// Core cycles per peripheral clock, and zero-wait internal latencies
	localparam logic [3:0]  PER_N2        = 4'h2;
	localparam logic [3:0]  PER_N4        = 4'h4;
	localparam logic [3:0]  INT_RD_CYC    = 4'h1;
	localparam logic [3:0]  INT_WR_CYC    = 4'h2;
	localparam logic [3:0]  LAT_ONE       = 4'h1;
	localparam logic [15:0] WORD_ZERO     = 16'h0000;
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;

	typedef enum logic [1:0] {K_PER, K_SYS, K_EV, K_IO} acc_kind_t;
	typedef enum logic {ST_IDLE, ST_BUSY} bridge_st_t;
endpackage

//--- logic/periph_clk_gen.sv
// Peripheral clock phase generator derived from the core clock
`timescale 1ns/1ps
module periph_clk_gen
	import sysctl_pkg::*;
(
	input  wire logic       clk_sys_in,
	input  wire logic       resetn_in,
	input  wire logic       ratio4_in,
	output logic      [1:0] phase_out,
	output logic            per_clk_out
);
	logic [1:0] phase_r;
	logic [1:0] phase_nxt;
	logic       clk_r;
	logic       clk_nxt;
	logic [3:0] n_cyc;

	// Phase wraps at the ratio; clock is high in the first half period
	always_comb begin
		n_cyc = ratio4_in ? PER_N4 : PER_N2;
		if ({2'h0, phase_r} >= n_cyc - LAT_ONE)
			phase_nxt = 2'h0;
		else
			phase_nxt = phase_r + 2'h1;
		clk_nxt = ({2'h0, phase_nxt} < (n_cyc >> 1));
	end

	// Registers only
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			phase_r <= 2'h0;
			clk_r   <= 1'b1;
		end else begin
			phase_r <= phase_nxt;
			clk_r   <= clk_nxt;
		end
	end

	assign phase_out   = phase_r;
	assign per_clk_out = clk_r;
endmodule

//--- logic/clock_out_mux.sv
// Source selector for the clock output pin
`timescale 1ns/1ps
module clock_out_mux
	import sysctl_pkg::*;
(
	input  wire logic [1:0] sel_in,
	input  wire logic       gpio_level_in,
	input  wire logic       wd_clk_in,
	input  wire logic       per_clk_in,
	input  wire logic       core_clk_in,
	output logic            pin_out
);
	// Plain mux; a glitch at a select change is accepted, software sets it
	// once at boot
	always_comb begin
		case (sel_in)
			CKO_GPIO: pin_out = gpio_level_in;
			CKO_WDOG: pin_out = wd_clk_in;
			CKO_PER:  pin_out = per_clk_in;
			CKO_CORE: pin_out = core_clk_in;
			default:  pin_out = gpio_level_in;
		endcase
	end
endmodule

//--- logic/periph_bus_bridge.sv
// Core to peripheral bus bridge with the system configuration registers
//
// Behaviour
// - Core runs at two or four times peripheral
// - 2x: read 3-4, write 4-5, back-to-back 4
// - 4x: read 5 to 8, write 6 to 9
// - 4x back-to-back accesses take eight cycles
// - Isolated write takes one cycle more than read
// - Event unit sits on core bus directly
// - 16-bit transfers, byte reads in low lane
// - Byte writes drop the upper eight bits
// - I/O space reaches no peripheral
// - Address bit 0 ignored in decoding
// - Unimplemented system bits read zero
// - Control 7018, status 701A, vector 701E
// - Reset bits written together; 01 does nothing
// - Reset gives 0/1; clock select on power-on
// - Clock select picks pin source
// - Control bits 13-8, 5-0 ignore writes
// - Soft reset sets status bit 10
// - Vector pending set on latch, cleared on read
// - Vector upper byte reads zero
`timescale 1ns/1ps
module periph_bus_bridge
	import sysctl_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        resetn_in,
	input  wire logic        por_resetn_in,
	input  wire logic        ratio4_in,
	input  wire logic        cpu_req_in,
	input  wire logic        cpu_wr_in,
	input  wire logic        cpu_io_in,
	input  wire logic [15:0] cpu_addr_in,
	input  wire logic [15:0] cpu_wdata_in,
	output logic      [15:0] cpu_rdata_out,
	output logic             cpu_ready_out,
	output logic      [15:0] per_addr_out,
	output logic      [15:0] per_wdata_out,
	output logic             per_rd_out,
	output logic             per_wr_out,
	input  wire logic [15:0] per_rdata_in,
	input  wire logic        per_byte_in,
	output logic             per_clk_out,
	output logic             ev_sel_out,
	output logic             ev_wr_out,
	input  wire logic [15:0] ev_rdata_in,
	input  wire logic        vec_latch_in,
	input  wire logic [7:0]  vec_offset_in,
	input  wire logic        wdog_reset_in,
	input  wire logic        bad_addr_in,
	input  wire logic        hpo_level_in,
	input  wire logic        afault_in,
	input  wire logic        gpio_level_in,
	input  wire logic        wd_clk_in,
	output logic             clock_output_pin_out,
	output logic             global_reset_out
);
	bridge_st_t  st_r,     st_nxt;
	acc_kind_t   kind_r,   kind_nxt;
	logic [3:0]  cnt_r,    cnt_nxt;
	logic [3:0]  lat_r,    lat_nxt;
	logic        wr_r,     wr_nxt;
	logic [15:0] addr_r,   addr_nxt;
	logic [15:0] wdata_r,  wdata_nxt;
	logic [15:0] rdata_r,  rdata_nxt;
	logic [1:0]  ph0_r,    ph0_nxt;
	logic        b2b_r,    b2b_nxt;
	logic        done_r;
	logic [1:0]  srst_r,   srst_nxt;
	logic        grst_r,   grst_nxt;
	logic [7:0]  vec_r,    vec_nxt;
	logic        vecp_r,   vecp_nxt;
	logic        hpo_take_r;
	logic [1:0]  cksel_r,  cksel_nxt;
	logic        porf_r,   porf_nxt;
	logic        badf_r,   badf_nxt;
	logic        swf_r,    swf_nxt;
	logic        wdf_r,    wdf_nxt;
	logic        hpof_r,   hpof_nxt;
	logic [1:0]  phase;
	logic        per_clk;
	acc_kind_t   req_kind;
	logic        accept;
	logic        sw_set;
	logic        ctl_wr;
	logic        vec_rd;
	logic [15:0] stat_clr;
	logic [15:0] stat_word;
	logic [1:0]  srst_wr;
	logic [3:0]  n_cyc;
	logic [3:0]  exp_lat;

	// Address bit 0 is dropped before any compare
	function automatic logic reg_is(input logic [15:0] a,
		input logic [15:0] base);
		reg_is = (a[15:1] == base[15:1]);
	endfunction

	// Event unit sits on the core bus, I/O space reaches nothing
	function automatic acc_kind_t kind_of(input logic io,
		input logic [15:0] a);
		if (io)
			kind_of = K_IO;
		else if ((a & SYS_MASK) == SYS_BASE)
			kind_of = K_SYS;
		else if ((a & EV_MASK) == EV_BASE)
			kind_of = K_EV;
		else
			kind_of = K_PER;
	endfunction

	// Peripheral latency: align to next peripheral edge, one period, one
	// return cycle, one more for a write; a chained access takes two periods
	function automatic logic [3:0] per_lat(input logic [3:0] n,
		input logic [1:0] ph, input logic wr, input logic b2b);
		if (b2b)
			per_lat = n << 1;
		else
			per_lat = (n - LAT_ONE - {2'h0, ph}) + n + LAT_ONE
				+ {3'h0, wr};
	endfunction

	periph_clk_gen u_clk_gen (
		.clk_sys_in  (clk_sys_in),
		.resetn_in   (resetn_in),
		.ratio4_in   (ratio4_in),
		.phase_out   (phase),
		.per_clk_out (per_clk)
	);

	clock_out_mux u_clk_mux (
		.sel_in        (cksel_r),
		.gpio_level_in (gpio_level_in),
		.wd_clk_in     (wd_clk_in),
		.per_clk_in    (per_clk),
		.core_clk_in   (clk_sys_in),
		.pin_out       (clock_output_pin_out)
	);

	assign n_cyc    = ratio4_in ? PER_N4 : PER_N2;
	assign req_kind = kind_of(cpu_io_in, cpu_addr_in);
	assign accept   = (st_r == ST_IDLE) && cpu_req_in;
	assign srst_wr  = {cpu_wdata_in[SRST_HI_BIT], cpu_wdata_in[SRST_LO_BIT]};

	// Unimplemented bits read as zero rather than floating
	always_comb begin
		stat_word              = WORD_ZERO;
		stat_word[ST_POR_BIT]  = porf_r;
		stat_word[ST_BAD_BIT]  = badf_r;
		stat_word[ST_SW_BIT]   = swf_r;
		stat_word[ST_WD_BIT]   = wdf_r;
		stat_word[ST_HPO_BIT]  = hpof_r;
		stat_word[ST_AF_BIT]   = afault_in;
		stat_word[ST_VEC_BIT]  = vecp_r;
	end

	// Bridge sequencer and core-domain system state
	always_comb begin
		st_nxt    = st_r;
		kind_nxt  = kind_r;
		cnt_nxt   = cnt_r;
		lat_nxt   = lat_r;
		wr_nxt    = wr_r;
		addr_nxt  = addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		ph0_nxt   = ph0_r;
		b2b_nxt   = b2b_r;
		srst_nxt  = srst_r;
		grst_nxt  = 1'b0;
		sw_set    = 1'b0;
		ctl_wr    = 1'b0;
		vec_rd    = 1'b0;
		stat_clr  = WORD_ZERO;
		vec_nxt   = vec_latch_in ? vec_offset_in : vec_r;
		case (st_r)
			ST_IDLE: begin
				if (cpu_req_in) begin
					st_nxt    = ST_BUSY;
					kind_nxt  = req_kind;
					wr_nxt    = cpu_wr_in;
					addr_nxt  = {cpu_addr_in[15:1], 1'b0};
					wdata_nxt = cpu_wdata_in;
					ph0_nxt   = phase;
					b2b_nxt   = done_r;
					lat_nxt   = LAT_ONE;
					rdata_nxt = WORD_ZERO;
					if (req_kind == K_PER)
						cnt_nxt = per_lat(n_cyc, phase, cpu_wr_in, done_r)
							- LAT_ONE;
					else
						cnt_nxt = (cpu_wr_in ? INT_WR_CYC : INT_RD_CYC)
							- LAT_ONE;
					// Internal reads are captured at once: zero wait state
					if (!cpu_wr_in && req_kind == K_EV)
						rdata_nxt = ev_rdata_in;
					if (!cpu_wr_in && req_kind == K_SYS) begin
						if (reg_is(cpu_addr_in, CTRL_ADDR))
							rdata_nxt = {srst_r, 6'h00, cksel_r, 6'h00};
						else if (reg_is(cpu_addr_in, STAT_ADDR))
							rdata_nxt = stat_word;
						else if (reg_is(cpu_addr_in, VEC_ADDR)) begin
							rdata_nxt = {BYTE_ZERO, vec_r};
							vec_rd    = 1'b1;
						end
					end
					if (cpu_wr_in && req_kind == K_SYS) begin
						// Reserved offsets decode to nothing
						if (reg_is(cpu_addr_in, CTRL_ADDR)) begin
							ctl_wr   = 1'b1;
							srst_nxt = srst_wr;
							// Every pair but 01 fires a global reset
							if (srst_wr != SRST_NOP) begin
								grst_nxt = 1'b1;
								sw_set   = 1'b1;
								srst_nxt = SRST_RESET;
							end
						end else if (reg_is(cpu_addr_in, STAT_ADDR))
							stat_clr = cpu_wdata_in;
					end
				end
			end
			ST_BUSY: begin
				lat_nxt = lat_r + LAT_ONE;
				// Core waits; read data taken on the edge that raises ready, one before the closing edge
				if (cnt_r != 4'h0)
					cnt_nxt = cnt_r - LAT_ONE;
				else
					st_nxt = ST_IDLE;
				if (kind_r == K_PER && !wr_r && cnt_r == LAT_ONE) begin
					if (per_byte_in)
						rdata_nxt = {BYTE_ZERO, per_rdata_in[7:0]};
					else
						rdata_nxt = per_rdata_in;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
		// Latch wins over a read-clear in the same cycle
		if (vec_latch_in)
			vecp_nxt = 1'b1;
		else if (vec_rd)
			vecp_nxt = 1'b0;
		else
			vecp_nxt = vecp_r;
	end

	// Core-domain registers under ordinary reset
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r       <= ST_IDLE;
			kind_r     <= K_PER;
			cnt_r      <= 4'h0;
			lat_r      <= 4'h0;
			wr_r       <= 1'b0;
			addr_r     <= 16'h0000;
			wdata_r    <= 16'h0000;
			rdata_r    <= 16'h0000;
			ph0_r      <= 2'h0;
			b2b_r      <= 1'b0;
			done_r     <= 1'b0;
			srst_r     <= SRST_RESET;
			grst_r     <= 1'b0;
			vec_r      <= 8'h00;
			vecp_r     <= 1'b0;
			hpo_take_r <= 1'b1;
		end else begin
			st_r       <= st_nxt;
			kind_r     <= kind_nxt;
			cnt_r      <= cnt_nxt;
			lat_r      <= lat_nxt;
			wr_r       <= wr_nxt;
			addr_r     <= addr_nxt;
			wdata_r    <= wdata_nxt;
			rdata_r    <= rdata_nxt;
			ph0_r      <= ph0_nxt;
			b2b_r      <= b2b_nxt;
			done_r     <= cpu_ready_out;
			srst_r     <= srst_nxt;
			grst_r     <= grst_nxt;
			vec_r      <= vec_nxt;
			vecp_r     <= vecp_nxt;
			hpo_take_r <= 1'b0;
		end
	end

	// Cause flags survive ordinary reset; hardware set wins over clear
	always_comb begin
		cksel_nxt = cksel_r;
		if (ctl_wr)
			cksel_nxt = {cpu_wdata_in[CKSEL_HI_BIT],
				cpu_wdata_in[CKSEL_LO_BIT]};
		porf_nxt = porf_r & ~stat_clr[ST_POR_BIT];
		badf_nxt = bad_addr_in | (badf_r & ~stat_clr[ST_BAD_BIT]);
		swf_nxt  = sw_set | (swf_r & ~stat_clr[ST_SW_BIT]);
		wdf_nxt  = wdog_reset_in | (wdf_r & ~stat_clr[ST_WD_BIT]);
		// Override level caught once after reset release, drops with pin
		hpof_nxt = hpo_level_in & (hpo_take_r
			| (hpof_r & ~stat_clr[ST_HPO_BIT]));
	end

	// Power-on domain: select field comes up as core clock output
	always_ff @(posedge clk_sys_in or negedge por_resetn_in) begin
		if (!por_resetn_in) begin
			cksel_r <= CKSEL_POR;
			porf_r  <= 1'b1;
			badf_r  <= 1'b0;
			swf_r   <= 1'b0;
			wdf_r   <= 1'b0;
			hpof_r  <= 1'b0;
		end else begin
			cksel_r <= cksel_nxt;
			porf_r  <= porf_nxt;
			badf_r  <= badf_nxt;
			swf_r   <= swf_nxt;
			wdf_r   <= wdf_nxt;
			hpof_r  <= hpof_nxt;
		end
	end

	// Bus outputs; upper lane zeroed for byte-wide peripherals
	assign cpu_ready_out    = (st_r == ST_BUSY) && (cnt_r == 4'h0);
	assign cpu_rdata_out    = rdata_r;
	assign per_addr_out     = addr_r;
	assign per_wdata_out    = per_byte_in ? {BYTE_ZERO, wdata_r[7:0]}
		: wdata_r;
	assign per_rd_out       = (st_r == ST_BUSY) && kind_r == K_PER && !wr_r;
	assign per_wr_out       = (st_r == ST_BUSY) && kind_r == K_PER && wr_r;
	assign per_clk_out      = per_clk;
	assign ev_sel_out       = (accept && req_kind == K_EV)
		|| (st_r == ST_BUSY && kind_r == K_EV);
	assign ev_wr_out        = ev_sel_out && (accept ? cpu_wr_in : wr_r);
	assign global_reset_out = grst_r;

	// Expected single-access latency from the start phase, worked out apart
	// from the counter load so that a slip there is caught
	assign exp_lat = (n_cyc << 1) - {2'h0, ph0_r} + {3'h0, wr_r};

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	AST_4X_READ: assert property (cpu_ready_out && kind_r == K_PER && !wr_r
		&& ratio4_in && !b2b_r |-> lat_r >= 4'h5 && lat_r <= 4'h8)
		else $error("4x read latency out of range");
	AST_4X_WRITE: assert property (cpu_ready_out && kind_r == K_PER
		&& wr_r && ratio4_in && !b2b_r |-> lat_r >= 4'h6 && lat_r <= 4'h9)
		else $error("4x write latency out of range");
	AST_2X_LAT: assert property (cpu_ready_out && kind_r == K_PER
		&& !ratio4_in |-> (b2b_r ? lat_r == 4'h4
		: lat_r == 4'h3 + {3'h0, wr_r} || lat_r == 4'h4 + {3'h0, wr_r}))
		else $error("2x latency out of range");
	AST_4X_CHAIN: assert property (cpu_ready_out && kind_r == K_PER
		&& b2b_r && ratio4_in |-> lat_r == 4'h8)
		else $error("chained 4x access not eight cycles");
	AST_WR_PLUS_ONE: assert property (cpu_ready_out && kind_r == K_PER
		&& !b2b_r |-> lat_r == exp_lat)
		else $error("latency disagrees with start phase");
	AST_BYTE_READ: assert property (st_r == ST_BUSY && kind_r == K_PER
		&& !wr_r && cnt_r == LAT_ONE && per_byte_in
		|=> cpu_rdata_out[15:8] == BYTE_ZERO)
		else $error("byte read not in low lane");
	AST_BYTE_WRITE: assert property (per_wr_out && per_byte_in
		|-> per_wdata_out[15:8] == BYTE_ZERO)
		else $error("byte write upper lane driven");
	AST_IO_SILENT: assert property (accept && cpu_io_in
		|=> !per_rd_out && !per_wr_out && !ev_sel_out)
		else $error("I/O access reached a peripheral");
	AST_SRST_NOP: assert property (accept && cpu_wr_in && !cpu_io_in
		&& reg_is(cpu_addr_in, CTRL_ADDR)
		|=> global_reset_out == ($past(srst_wr) != SRST_NOP))
		else $error("soft reset pair decoded wrongly");
	AST_SW_FLAG: assert property (global_reset_out |-> swf_r)
		else $error("soft reset cause flag not set");
	AST_VEC_CLEAR: assert property (vec_rd && !vec_latch_in
		|=> !vecp_r ##1 cpu_rdata_out[15:8] == BYTE_ZERO)
		else $error("vector pending not cleared by read");
	AST_CKO_WDOG: assert property (cksel_r == CKO_WDOG
		|-> clock_output_pin_out == wd_clk_in)
		else $error("clock pin not following watchdog clock");

	COV_4X_READ: cover property (cpu_ready_out && ratio4_in && !wr_r
		&& kind_r == K_PER);
	COV_CHAIN: cover property (cpu_ready_out && b2b_r && kind_r == K_PER);
	COV_SRST: cover property (global_reset_out);
	COV_VEC: cover property (vec_rd);
endmodule

//--- verif/periph_partner.sv
// Behavioural model of the slow peripheral bus side of the bridge
`timescale 1ns/1ps
module periph_partner
	import sysctl_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        per_rd_in,
	input  wire logic        per_wr_in,
	input  wire logic [15:0] per_addr_in,
	input  wire logic [15:0] per_wdata_in,
	output logic      [15:0] per_rdata_out,
	output logic             per_byte_out,
	output logic      [15:0] last_wdata_out
);
	logic [15:0] hold_r = 16'h0000;

	// Byte wide peripherals live at 71xx; upper data lane is garbage there
	assign per_byte_out = (per_addr_in[11:8] == 4'h1);

	// Released bus shows a pattern that flips every cycle, never stale data
	always_comb begin
		if (per_rd_in)
			per_rdata_out = ~per_addr_in;
		else
			per_rdata_out = ~hold_r;
	end

	// Remember the last driven value and the last written word
	always_ff @(posedge clk_sys_in) begin
		hold_r <= per_rdata_out;
		if (per_wr_in)
			last_wdata_out <= per_wdata_in;
	end
endmodule

//--- verif/tb_peripheral_bus_bridge_sysctl.sv
// Self-checking bench for the peripheral bus bridge and system block
`timescale 1ns/1ps
module tb_peripheral_bus_bridge_sysctl;
	import sysctl_pkg::*;
	logic        clk = 1'b0, resetn = 1'b0, por_n = 1'b0, ratio4 = 1'b0;
	logic        req = 1'b0, wr = 1'b0, io = 1'b0, vec_latch = 1'b0;
	logic        wdog = 1'b0, bad = 1'b0, afault = 1'b0;
	logic        gpio = 1'b0, watchdog_tick_clock = 1'b0;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000, ev_rdata = 16'h3C5A;
	logic [7:0]  vec_off = 8'h00;
	logic [15:0] rdata, per_addr, per_wdata, per_rdata, last_wd, rv;
	logic        ready, per_rd, per_wr, per_byte, per_clk, ev_sel, pin;
	logic        grst, saw_rd, saw_wr, saw_ev, ev_wr, saw_evw;
	int          num_errors = 0, checks_done = 0, grst_cnt = 0, cyc, gap;

	always #2.5 clk = ~clk;

	// Count software global reset pulses
	always @(posedge clk) begin
		if (grst === 1'b1)
			grst_cnt++;
	end

	periph_bus_bridge u_dut (
		.clk_sys_in(clk), .resetn_in(resetn), .por_resetn_in(por_n),
		.ratio4_in(ratio4), .cpu_req_in(req), .cpu_wr_in(wr),
		.cpu_io_in(io), .cpu_addr_in(addr), .cpu_wdata_in(wdata),
		.cpu_rdata_out(rdata), .cpu_ready_out(ready),
		.per_addr_out(per_addr), .per_wdata_out(per_wdata),
		.per_rd_out(per_rd), .per_wr_out(per_wr),
		.per_rdata_in(per_rdata), .per_byte_in(per_byte),
		.per_clk_out(per_clk), .ev_sel_out(ev_sel), .ev_wr_out(ev_wr),
		.ev_rdata_in(ev_rdata), .vec_latch_in(vec_latch),
		.vec_offset_in(vec_off), .wdog_reset_in(wdog),
		.bad_addr_in(bad), .hpo_level_in(1'b0), .afault_in(afault),
		.gpio_level_in(gpio), .wd_clk_in(watchdog_tick_clock),
		.clock_output_pin_out(pin), .global_reset_out(grst)
	);

	periph_partner u_partner (
		.clk_sys_in(clk), .per_rd_in(per_rd), .per_wr_in(per_wr),
		.per_addr_in(per_addr), .per_wdata_in(per_wdata),
		.per_rdata_out(per_rdata), .per_byte_out(per_byte),
		.last_wdata_out(last_wd)
	);

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wrap_up;
		$display("checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Starts at a falling edge, holds the request through the ready edge
	task automatic acc(input logic w, input logic i, input logic [15:0] a,
			input logic [15:0] d);
		int n;
		n = 0;
		req = 1'b1;
		wr = w;
		io = i;
		addr = a;
		wdata = d;
		{saw_rd, saw_wr, saw_ev, saw_evw} = 4'h0;
		do begin
			@(negedge clk);
			n++;
			saw_rd |= per_rd;
			saw_wr |= per_wr;
			saw_ev |= ev_sel;
			saw_evw |= ev_wr;
		end while (ready !== 1'b1 && n < 40);
		if (n >= 40) begin
			num_errors++;
			$display("ERROR t=%0t no ready", $time);
		end
		rv = rdata;
		cyc = n;
		@(negedge clk);
	endtask

	task idle;
		req = 1'b0;
		@(negedge clk);
	endtask

	task automatic rd_sys(input logic [15:0] a);
		acc(1'b0, 1'b0, a, 16'h0000);
		idle;
	endtask

	task automatic wr_sys(input logic [15:0] a, input logic [15:0] d);
		acc(1'b1, 1'b0, a, d);
		idle;
	endtask

	task automatic do_reset(input logic por, input logic r4);
		req = 1'b0;
		resetn = 1'b0;
		por_n = ~por;
		ratio4 = r4;
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		por_n = 1'b1;
		@(negedge clk);
	endtask

	// Ends at the falling edge just after a peripheral clock rise
	task automatic sync;
		logic prev;
		gap = 0;
		do begin
			prev = per_clk;
			@(negedge clk);
			gap++;
		end while (!(prev === 1'b0 && per_clk === 1'b1) && gap < 40);
	endtask

	// Isolated accesses at every phase, then a back-to-back train
	task automatic timing_run(input int n);
		int rc, wc, seen, c1, c2;
		seen = 0;
		sync;
		sync;
		check(16'(gap), 16'(n));
		for (int k = 0; k < n; k++) begin
			sync;
			repeat (k) @(negedge clk);
			rd_sys(16'h7200);
			rc = cyc;
			sync;
			repeat (k) @(negedge clk);
			wr_sys(16'h7200, 16'h1111);
			wc = cyc;
			check(16'(wc), 16'(rc + 1));
			if (rc > n && rc <= 2 * n)
				seen |= 1 << (rc - n - 1);
		end
		check(16'(seen), 16'((1 << n) - 1));
		acc(1'b0, 1'b0, 16'h7204, 16'h0000);
		acc(1'b1, 1'b0, 16'h7204, 16'h2222);
		c1 = cyc;
		acc(1'b0, 1'b0, 16'h7204, 16'h0000);
		c2 = cyc;
		idle;
		check(rv, 16'h8DFB);
		check(16'(c1), 16'(2 * n));
		check(16'(c2), 16'(2 * n));
		$display("test timing x%0d done", n);
	endtask

	task automatic lanes;
		rd_sys(16'h7103);
		check(rv, 16'h00FD);
		rd_sys(16'h7205);
		check(rv, 16'h8DFB);
		wr_sys(16'h7100, 16'hBEEF);
		check(last_wd, 16'h00EF);
		wr_sys(16'h7200, 16'hBEEF);
		check(last_wd, 16'hBEEF);
		$display("test lanes done");
	endtask

	// Reserved system words, event unit and I/O space stay off the bus
	task automatic spaces;
		logic [15:0] rsv [5] = '{16'h7010, 16'h7012, 16'h7014, 16'h7016,
			16'h701C};
		foreach (rsv[i]) begin
			rd_sys(rsv[i]);
			check(16'(cyc), 16'h0001);
			check({15'h0000, saw_rd}, 16'h0000);
			check(rv, 16'h0000);
		end
		rd_sys(16'h7400);
		check(rv, 16'h3C5A);
		check({14'h0000, saw_ev, saw_rd}, 16'h0002);
		check({15'h0000, saw_evw}, 16'h0000);
		wr_sys(16'h7402, 16'h5555);
		check({14'h0000, saw_ev, saw_wr}, 16'h0002);
		check({15'h0000, saw_evw}, 16'h0001);
		check(16'(cyc), 16'h0002);
		rd_sys(16'h7018);
		rd_sys(16'h7400);
		acc(1'b0, 1'b1, 16'h7400, 16'h0000);
		idle;
		check(rv, 16'h0000);
		check({13'h0000, saw_rd, saw_wr, saw_ev}, 16'h0000);
		$display("test spaces done");
	endtask

	function automatic logic src(input int s);
		case (s)
			0: return gpio;
			1: return watchdog_tick_clock;
			2: return per_clk;
			default: return clk;
		endcase
	endfunction

	task automatic clock_select;
		for (int s = 0; s < 4; s++) begin
			wr_sys(16'h7018, {2'b01, 6'h3F, 2'(s), 6'h3F});
			rd_sys(16'h7019);
			check(rv, {2'b01, 6'h00, 2'(s), 6'h00});
			for (int j = 0; j < 4; j++) begin
				gpio = j[0];
				watchdog_tick_clock = j[1];
				#1 check({15'h0000, pin}, {15'h0000, src(s)});
				@(posedge clk);
				#1 check({15'h0000, pin}, {15'h0000, src(s)});
				@(negedge clk);
			end
		end
		$display("test clock select done");
	endtask

	task automatic soft_reset;
		logic [1:0] pairs [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
		int b;
		foreach (pairs[i]) begin
			b = grst_cnt;
			wr_sys(16'h7018, {pairs[i], 6'h00, 2'b11, 6'h00});
			repeat (4) @(negedge clk);
			check(16'(grst_cnt - b), 16'(pairs[i] != 2'b01));
			rd_sys(16'h701A);
			check(rv & 16'h0400, (pairs[i] != 2'b01) ? 16'h0400 : 16'h0000);
			rd_sys(16'h7018);
			check(rv & 16'hC000, 16'h4000);
			wr_sys(16'h701A, 16'h0400);
		end
		$display("test soft reset done");
	endtask

	task automatic status_vector;
		{wdog, bad, afault} = 3'b111;
		@(negedge clk);
		{wdog, bad} = 2'b00;
		rd_sys(16'h701A);
		check(rv & 16'h1208, 16'h1208);
		vec_off = 8'hA7;
		vec_latch = 1'b1;
		@(negedge clk);
		vec_latch = 1'b0;
		rd_sys(16'h701A);
		check(rv & 16'h0001, 16'h0001);
		rd_sys(16'h701F);
		check(rv, 16'h00A7);
		rd_sys(16'h701A);
		check(rv & 16'h0001, 16'h0000);
		$display("test status vector done");
	endtask

	// Main sequence: power-on in 2x mode, ordinary reset into 4x mode
	initial begin
		do_reset(1'b1, 1'b0);
		rd_sys(16'h7018);
		check(rv & 16'hC0C0, 16'h40C0);
		timing_run(2);
		wr_sys(16'h7018, 16'h4080);
		do_reset(1'b0, 1'b1);
		rd_sys(16'h7018);
		check(rv & 16'hC0C0, 16'h4080);
		timing_run(4);
		lanes;
		spaces;
		clock_select;
		soft_reset;
		status_vector;
		wrap_up;
	end

	// The full run needs a few hundred cycles; this span is generous
	initial begin
		#100000;
		num_errors++;
		$display("ERROR t=%0t watchdog expired", $time);
		wrap_up;
	end
endmodule
